// File: core/msr_params.svh
`ifndef MSR_PARAMS_SVH
`define MSR_PARAMS_SVH

// register indexes; byte address is four times the index
`define MSR_IDX_STATUS_PINS   8'h08
`define MSR_IDX_STATUS_UNITS  8'h09
`define MSR_IDX_CONTROL       8'h10

`define MSR_ADDR_WIDTH        8

`define MSR_RST_STATUS_PINS   8'h00
`define MSR_RST_STATUS_UNITS  8'h01
`define MSR_RST_CONTROL       8'h00

// fields of mgmt_irq_status_units
`define MSR_BIT_PRINTER       0
`define MSR_BIT_SERIAL_TWO    1
`define MSR_BIT_SERIAL_ONE    2
`define MSR_BIT_FLOPPY        3
`define MSR_BIT_EVENT_B3      4
`define MSR_BIT_EVENT_B4      5
`define MSR_UNITS_USED_MASK   8'h3f

// fields of the control register
`define MSR_BIT_PRINTER_ACT   0
`define MSR_CONTROL_MASK      8'h01

`endif

// File: core/msr_pkg.sv
`default_nettype none

package msr_pkg;

    typedef logic [7:0] msr_byte_t;

    typedef enum logic [1:0] {
        MSR_SEL_NONE,
        MSR_SEL_PINS,
        MSR_SEL_UNITS,
        MSR_SEL_CONTROL
    } msr_sel_t;

endpackage

`default_nettype wire

// File: core/msr_status_regs.sv
// Local design decision: the APB register port.
`include "msr_params.svh"
`default_nettype none

// Functional notes
// - The pin status register holds one event bit per first-group pin in pin order and resets to zero on the standby power-on reset.
// - Each pin status bit clears when software writes a one to it.
// - The unit status register holds printer, serial two, serial one, floppy, two pin events and reserved top bits, resetting to 0x01.
// - Unit status bits 3 to 1 mirror their sources, ignore writes and clear only when the source drops.
// - Unit status bits 5 and 4 latch their pin events and clear on a write of one.
// - The printer bit reads one while the printer port is not activated and is forced to one by every reset.
// - With the printer port activated the printer bit tracks the acknowledge input level.
module msr_status_regs
    import msr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        main_power_on_reset,
    input  wire logic        hard_reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        pin_event_a0,
    input  wire logic        pin_event_a1,
    input  wire logic        pin_event_a2,
    input  wire logic        pin_event_a3,
    input  wire logic        pin_event_a4,
    input  wire logic        pin_event_a5,
    input  wire logic        pin_event_a6,
    input  wire logic        pin_event_a7,
    input  wire logic        pin_event_b3,
    input  wire logic        pin_event_b4,
    input  wire logic        printer_acknowledge_n,
    input  wire logic        serial_two_irq,
    input  wire logic        serial_one_irq,
    input  wire logic        floppy_irq,
    output logic      [7:0]  mgmt_irq_status_pins,
    output logic      [7:0]  mgmt_irq_status_units,
    output logic             printer_port_active
);

    // new value of a write-one-to-clear bit; a set beats a clear
    function automatic logic w1c_next(input logic cur,
                                      input logic ev,
                                      input logic clr);
        w1c_next = ev | (cur & ~clr);
    endfunction

    msr_byte_t  pin_events;
    msr_sel_t   sel;
    logic       mapped;
    logic       addr_aligned;
    logic [7:0] index;
    logic       wr_commit;
    logic       lane0_wr;
    msr_byte_t  wbyte;
    msr_byte_t  read_byte;
    logic       next_pready;
    logic       printer_bit;
    logic       next_printer_active;
    logic       any_reset_printer;

    assign pin_events = {pin_event_a7, pin_event_a6, pin_event_a5,
                         pin_event_a4, pin_event_a3, pin_event_a2,
                         pin_event_a1, pin_event_a0};

    // address decode: word aligned, index in bits 9:2
    assign addr_aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
    assign index        = paddr[9:2];
    assign sel = !addr_aligned                      ? MSR_SEL_NONE :
                 (index == `MSR_IDX_STATUS_PINS)    ? MSR_SEL_PINS :
                 (index == `MSR_IDX_STATUS_UNITS)   ? MSR_SEL_UNITS :
                 (index == `MSR_IDX_CONTROL)        ? MSR_SEL_CONTROL :
                                                      MSR_SEL_NONE;
    assign mapped = (sel != MSR_SEL_NONE);

    // write lands on the edge that sees pready high
    assign next_pready = psel & penable & ~pready;
    assign wr_commit   = psel & penable & pready & pwrite & mapped;
    assign lane0_wr    = wr_commit & pstrb[0];
    assign wbyte       = pwdata[7:0];

    assign read_byte =
        (sel == MSR_SEL_PINS)    ? mgmt_irq_status_pins :
        (sel == MSR_SEL_UNITS)   ? mgmt_irq_status_units :
        (sel == MSR_SEL_CONTROL) ? {7'h00, printer_port_active} :
                                   8'h00;

    // any reset drops activation, so the printer bit reads one
    assign any_reset_printer = rst | main_power_on_reset | hard_reset;
    assign next_printer_active =
        (lane0_wr && sel == MSR_SEL_CONTROL) ?
        wbyte[`MSR_BIT_PRINTER_ACT] : printer_port_active;
    assign printer_bit = printer_port_active ? printer_acknowledge_n
                                             : 1'b1;

    always_ff @(posedge clock) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            if (next_pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : {24'h000000, read_byte};
                pslverr <= ~mapped;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (any_reset_printer) begin
            printer_port_active <= 1'b0;
        end else begin
            printer_port_active <= next_printer_active;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pins
            logic clr;
            assign clr = lane0_wr && (sel == MSR_SEL_PINS) && wbyte[g];
            always_ff @(posedge clock) begin
                if (rst) begin
                    mgmt_irq_status_pins[g] <= 1'b0;
                end else begin
                    mgmt_irq_status_pins[g] <=
                        w1c_next(mgmt_irq_status_pins[g],
                                 pin_events[g], clr);
                end
            end
        end
    endgenerate

    logic clr_b3;
    logic clr_b4;
    assign clr_b3 = lane0_wr && (sel == MSR_SEL_UNITS)
                    && wbyte[`MSR_BIT_EVENT_B3];
    assign clr_b4 = lane0_wr && (sel == MSR_SEL_UNITS)
                    && wbyte[`MSR_BIT_EVENT_B4];

    always_ff @(posedge clock) begin
        if (rst) begin
            mgmt_irq_status_units <= `MSR_RST_STATUS_UNITS;
        end else begin
            mgmt_irq_status_units[7:6] <= 2'b00;
            mgmt_irq_status_units[`MSR_BIT_EVENT_B4] <=
                w1c_next(mgmt_irq_status_units[`MSR_BIT_EVENT_B4],
                         pin_event_b4, clr_b4);
            mgmt_irq_status_units[`MSR_BIT_EVENT_B3] <=
                w1c_next(mgmt_irq_status_units[`MSR_BIT_EVENT_B3],
                         pin_event_b3, clr_b3);
            mgmt_irq_status_units[`MSR_BIT_FLOPPY]     <= floppy_irq;
            mgmt_irq_status_units[`MSR_BIT_SERIAL_ONE] <= serial_one_irq;
            mgmt_irq_status_units[`MSR_BIT_SERIAL_TWO] <= serial_two_irq;
            mgmt_irq_status_units[`MSR_BIT_PRINTER] <=
                (main_power_on_reset | hard_reset) ? 1'b1 : printer_bit;
        end
    end

endmodule // msr_status_regs

`default_nettype wire

// File: testbench/msr_status_properties.sv
`default_nettype none
module msr_status_properties (
    input wire logic clock, rst, main_power_on_reset, hard_reset, psel,
    input wire logic penable, pwrite, pready, pin_event_a1, pin_event_b3,
    input wire logic printer_acknowledge_n, serial_two_irq, serial_one_irq,
    input wire logic floppy_irq, printer_port_active,
    input wire logic [31:0] paddr, pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [7:0]  mgmt_irq_status_pins, mgmt_irq_status_units
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_rst; $fell(rst) |-> mgmt_irq_status_pins == 8'h00
        && mgmt_irq_status_units == 8'h01; endproperty
    property p_mirror; !$past(rst) |-> mgmt_irq_status_units[3:1] ==
        $past({floppy_irq, serial_one_irq, serial_two_irq}); endproperty
    property p_idle; !printer_port_active |=> mgmt_irq_status_units[0];
    endproperty
    property p_track; printer_port_active && !main_power_on_reset &&
        !hard_reset |=> mgmt_irq_status_units[0] ==
        $past(printer_acknowledge_n); endproperty
    property p_force; main_power_on_reset || hard_reset |=>
        mgmt_irq_status_units[0] && !printer_port_active; endproperty
    property p_set_a; pin_event_a1 |=> mgmt_irq_status_pins[1]; endproperty
    property p_set_b; pin_event_b3 |=> mgmt_irq_status_units[4]; endproperty
    property p_w1c; psel && penable && pready && pwrite && paddr == 32'h20
        && pstrb[0] && pwdata[1] && !pin_event_a1 |=>
        !mgmt_irq_status_pins[1]; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    a_mirror: assert property (p_mirror) else $error("bad mirror");
    a_idle: assert property (p_idle) else $error("bad idle");
    a_track: assert property (p_track) else $error("bad track");
    a_force: assert property (p_force) else $error("bad force");
    a_set_a: assert property (p_set_a) else $error("bad set");
    a_set_b: assert property (p_set_b) else $error("bad set b");
    a_w1c: assert property (p_w1c) else $error("bad clear");
    c_track: cover property (printer_port_active && !printer_acknowledge_n);
    c_write: cover property (pready && pwrite);
    c_hard: cover property (hard_reset);
endmodule // msr_status_properties
`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, main_power_on_reset = 0, hard_reset = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic printer_port_active;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r, rd;
    logic [3:0]  pstrb = 4'hf, src = '0;
    logic [9:0]  ev = '0;
    logic [7:0]  mgmt_irq_status_pins, mgmt_irq_status_units, pm = '0;
    logic [1:0]  ub = '0;
    logic        act = 0;
    int          fail_count = 0, checked = 0, x = 70;
    wire logic pin_event_a0, pin_event_a1, pin_event_a2, pin_event_a3;
    wire logic pin_event_a4, pin_event_a5, pin_event_a6, pin_event_a7;
    wire logic pin_event_b3, pin_event_b4, printer_acknowledge_n;
    wire logic serial_two_irq, serial_one_irq, floppy_irq;
    assign {pin_event_b4, pin_event_b3, pin_event_a7, pin_event_a6,
        pin_event_a5, pin_event_a4, pin_event_a3, pin_event_a2,
        pin_event_a1, pin_event_a0} = ev;
    assign {printer_acknowledge_n, floppy_irq, serial_one_irq,
        serial_two_irq} = src;
    msr_status_regs DUT (.*);
    initial forever #5 clock = ~clock;
    function automatic int rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] v);
        checked++;
        if (s !== v) begin
            fail_count++;
            $display("unexpected %0t seen %h wanted %h", $time, s, v);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clock)
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock) penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic report_and_stop();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 0;
        apb(0, 32'h20, 0); chk(rd, 0);
        apb(0, 32'h24, 0); chk(rd, 1);
        apb(1, 32'h30, 32'hff); chk({rd[30:0], e}, 1);
        for (int i = 0; i < 12; i++) begin
            if (i % 3 == 1) begin
                apb(1, 32'h40, 1);
                act = 1;
            end
            if (i == 4) begin
                @(posedge clock) main_power_on_reset <= 1;
                @(posedge clock) main_power_on_reset <= 0;
                act = 0;
            end
            if (i == 8) begin
                @(posedge clock) hard_reset <= 1;
                @(posedge clock) hard_reset <= 0;
                act = 0;
            end
            r = rnd();
            @(posedge clock) {src, ev} <= r[13:0];
            @(posedge clock) ev <= '0;
            pm |= r[7:0];
            ub |= r[9:8];
            chk(printer_port_active, act);
            apb(0, 32'h20, 0); chk(rd, pm);
            apb(0, 32'h24, 0);
            chk(rd, {ub, r[12:10], act ? r[13] : 1'b1});
            r = rnd();
            apb(1, 32'h20, r); pm &= ~r[7:0];
            apb(1, 32'h24, r); ub &= ~r[5:4];
        end
        // write without lane 0 strobe must leave the bits set
        @(posedge clock) ev <= 10'h0ff;
        @(posedge clock) ev <= '0;
        pstrb <= 4'he;
        apb(1, 32'h20, 32'hff);
        pstrb <= 4'hf;
        apb(0, 32'h20, 0); chk(rd, 32'hff);
        apb(0, 32'h40, 0); chk(rd, act);
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        report_and_stop();
    end
endmodule // tb_top
bind msr_status_regs msr_status_properties u_prop (.*);
`default_nettype wire
